// *** rtl/femrm_pkg.sv ***
// package: constants for the flash emulation ram remap block
package femrm_pkg;
   // address widths and ram depth in words
   localparam int ADDR_W        = 32;
   localparam int RAM_AW        = 16;
   localparam int RAM_WORDS     = 16;
   // bank fields
   localparam int LARGE_COUNT   = 4;
   localparam int SMALL_COUNT   = 2;
   localparam int LARGE_FIELD_W = 7;
   localparam int SMALL_FIELD_W = 8;
   localparam int LARGE_LO      = 12;
   localparam int LARGE_HI      = 18;
   localparam int SMALL_LO      = 12;
   localparam int SMALL_HI      = 19;
   localparam int LARGE_OFS_W   = 13;
   localparam int SMALL_OFS_W   = 12;
   // internal ram window
   localparam logic [31:0] RAM_FIRST   = 32'h0080_4000;
   localparam logic [31:0] RAM_LAST    = 32'h0080_dfff;
   localparam logic [31:0] SMALL_BASE  = 32'h0080_c000;
   localparam logic [31:0] LARGE_SPAN  = 32'h0000_2000;
   localparam logic [31:0] SMALL_SPAN  = 32'h0000_1000;
   // flash array address range
   localparam logic [31:0] FLASH_LAST  = 32'h000f_ffff;
   // reset values
   localparam logic [7:0]  FIELD_RESET = 8'h00;
   localparam logic        BIT_RESET   = 1'b0;
   // access path
   typedef enum logic [1:0]
   {
      FEMRM_PATH_NONE  = 2'b00,
      FEMRM_PATH_RAM   = 2'b01,
      FEMRM_PATH_REMAP = 2'b11,
      FEMRM_PATH_FLASH = 2'b10
   } femrm_path_t;
endpackage

// *** rtl/femrm_ram.sv ***
// file: small internal ram model with registered read data
`timescale 1ns/1ps
module femrm_ram
(
   // clock and reset
   input  wire logic                            clock,
   input  wire logic                            rst,
   // access port
   input  wire logic                            req,
   input  wire logic                            we,
   input  wire logic [femrm_pkg::RAM_AW-1:0]    addr,
   input  wire logic [31:0]                     wdata,
   output logic      [31:0]                     rdata
);
   logic [31:0] mem [femrm_pkg::RAM_WORDS];
   logic [31:0] next_rdata;
   logic [3:0]  idx;

   // ---------------------------------------------
   // storage
   // ---------------------------------------------
   assign idx = addr[5:2];

   always_comb
   begin
      next_rdata = rdata;
      if (req && !we)
      begin
         next_rdata = mem[idx];
      end
   end

   always_ff @(posedge clock)
   begin
      if (req && we)
      begin
         mem[idx] <= wdata;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end
endmodule

// *** rtl/femrm_top.sv ***
// file: flash emulation address remap in front of internal ram
`timescale 1ns/1ps
module femrm_top
(
   // clock and reset
   input  wire logic                                   clock,
   input  wire logic                                   rst,
   // control bits
   input  wire logic                                   emulation_mode_bit,
   input  wire logic [femrm_pkg::LARGE_COUNT-1:0]      large_bank_enables,
   input  wire logic [femrm_pkg::SMALL_COUNT-1:0]      small_bank_enables,
   input  wire logic [femrm_pkg::LARGE_COUNT*7-1:0]    large_bank_addr_field,
   input  wire logic [femrm_pkg::SMALL_COUNT*8-1:0]    small_bank_addr_field,
   // cpu access
   input  wire logic                                   cpu_req,
   input  wire logic                                   cpu_we,
   input  wire logic [31:0]                            cpu_addr,
   input  wire logic [31:0]                            cpu_wdata,
   output logic      [31:0]                            cpu_rdata,
   // flash side
   output logic                                        flash_req,
   // status
   output logic                                        remap_hit,
   output logic      [2:0]                             remap_source,
   output logic      [femrm_pkg::RAM_AW-1:0]           ram_addr
);
   localparam int NB = femrm_pkg::LARGE_COUNT + femrm_pkg::SMALL_COUNT;

   logic [NB-1:0]               match;
   logic [31:0]                 base [NB];
   logic [31:0]                 phys;
   logic                        own_ram;
   logic                        is_flash;
   logic                        hit;
   logic [2:0]                  src;
   logic                        ram_req;
   logic [femrm_pkg::RAM_AW-1:0] ram_a;
   femrm_pkg::femrm_path_t      path;
   femrm_pkg::femrm_path_t      next_path;
   logic [2:0]                  next_src;
   logic [femrm_pkg::RAM_AW-1:0] next_ram_addr;
   logic [31:0]                 ram_ofs;

   // ---------------------------------------------
   // per-bank compare
   // ---------------------------------------------
   assign is_flash = cpu_addr <= femrm_pkg::FLASH_LAST;

   for (genvar i = 0; i < NB; i++)
   begin : g_bank
      if (i < femrm_pkg::LARGE_COUNT)
      begin : g_large
         assign match[i] = emulation_mode_bit && large_bank_enables[i]
            && is_flash
            && cpu_addr[femrm_pkg::LARGE_HI:femrm_pkg::LARGE_LO]
               == large_bank_addr_field[i*7 +: 7];
         assign base[i] = femrm_pkg::RAM_FIRST
            + femrm_pkg::LARGE_SPAN * i;
      end
      else
      begin : g_small
         assign match[i] = emulation_mode_bit
            && small_bank_enables[i-femrm_pkg::LARGE_COUNT]
            && is_flash
            && cpu_addr[femrm_pkg::SMALL_HI:femrm_pkg::SMALL_LO]
               == small_bank_addr_field[(i-femrm_pkg::LARGE_COUNT)*8 +: 8];
         assign base[i] = femrm_pkg::SMALL_BASE
            + femrm_pkg::SMALL_SPAN * (i - femrm_pkg::LARGE_COUNT);
      end
   end

   // ---------------------------------------------
   // priority and address forming
   // ---------------------------------------------
   always_comb
   begin
      hit  = 1'b0;
      src  = 3'h0;
      phys = cpu_addr;
      for (int k = NB - 1; k >= 0; k--)
      begin
         if (match[k])
         begin
            hit = 1'b1;
            src = k[2:0];
            if (k < femrm_pkg::LARGE_COUNT)
            begin
               phys = base[k]
                  | {19'h0, cpu_addr[femrm_pkg::LARGE_OFS_W-1:0]};
            end
            else
            begin
               phys = base[k]
                  | {20'h0, cpu_addr[femrm_pkg::SMALL_OFS_W-1:0]};
            end
         end
      end
   end

   assign own_ram = cpu_addr >= femrm_pkg::RAM_FIRST
      && cpu_addr <= femrm_pkg::RAM_LAST;
   assign ram_ofs = phys - femrm_pkg::RAM_FIRST;
   assign ram_a   = ram_ofs[femrm_pkg::RAM_AW-1:0];
   assign ram_req = cpu_req && (hit || own_ram);

   // ---------------------------------------------
   // access path and status registers
   // ---------------------------------------------
   always_comb
   begin
      next_path     = femrm_pkg::FEMRM_PATH_NONE;
      next_src      = remap_source;
      next_ram_addr = ram_addr;
      if (cpu_req)
      begin
         if (hit)
         begin
            next_path     = femrm_pkg::FEMRM_PATH_REMAP;
            next_src      = src;
            next_ram_addr = ram_a;
         end
         else if (own_ram)
         begin
            next_path     = femrm_pkg::FEMRM_PATH_RAM;
            next_ram_addr = ram_a;
         end
         else if (is_flash)
         begin
            next_path = femrm_pkg::FEMRM_PATH_FLASH;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         path         <= femrm_pkg::FEMRM_PATH_NONE;
         remap_source <= 3'h0;
         ram_addr     <= 16'h0000;
      end
      else
      begin
         path         <= next_path;
         remap_source <= next_src;
         ram_addr     <= next_ram_addr;
      end
   end

   // status pulses decode the registered path
   assign remap_hit = path == femrm_pkg::FEMRM_PATH_REMAP;
   assign flash_req = path == femrm_pkg::FEMRM_PATH_FLASH;

   // ---------------------------------------------
   // ram
   // ---------------------------------------------
   femrm_ram u_ram
   (
      .clock (clock),
      .rst   (rst),
      .req   (ram_req),
      .we    (cpu_we),
      .addr  (ram_a),
      .wdata (cpu_wdata),
      .rdata (cpu_rdata)
   );

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   a_no_remap_off: assert property (@(posedge clock)
      disable iff (rst) !emulation_mode_bit |=> !remap_hit)
      else $error("remap while emulation off");
   a_enable_needed: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && large_bank_enables == 4'h0
       && small_bank_enables == 2'h0) |=> !remap_hit)
      else $error("remap without bank enable");
   a_large0_wins: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && match[0]) |=> remap_hit && remap_source == 3'h0)
      else $error("large bank 0 lost priority");
   a_large0_addr: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && match[0])
      |=> ram_addr == {3'h0, $past(cpu_addr[12:0])})
      else $error("large bank 0 address wrong");
   a_small0_addr: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && match[4] && match[3:0] == 4'h0)
      |=> ram_addr == {4'h8, $past(cpu_addr[11:0])})
      else $error("small bank 0 address wrong");
   a_own_ram: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && own_ram) |=> !flash_req)
      else $error("own ram access sent to flash");
   a_flash_pass: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && is_flash && !hit) |=> flash_req && !remap_hit)
      else $error("plain flash access lost");
   a_large_field: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && emulation_mode_bit && large_bank_enables[1]
       && !large_bank_enables[0] && cpu_addr[31:20] == 12'h000
       && cpu_addr[18:12] == large_bank_addr_field[13:7])
      |=> remap_hit && remap_source == 3'h1)
      else $error("large compare wrong");
   a_small_field: assert property (@(posedge clock)
      disable iff (rst)
      (cpu_req && emulation_mode_bit && small_bank_enables[1]
       && !small_bank_enables[0] && large_bank_enables == 4'h0
       && cpu_addr[31:20] == 12'h000
       && cpu_addr[19:12] == small_bank_addr_field[15:8])
      |=> remap_hit && remap_source == 3'h5)
      else $error("small compare wrong");
   c_remap: cover property (@(posedge clock) cpu_req && hit);
   c_overlap: cover property (@(posedge clock) cpu_req && match[0] && match[1]);
   c_small: cover property (@(posedge clock) cpu_req && match[5]);
   c_own: cover property (@(posedge clock) cpu_req && own_ram);
endmodule

// *** test/femrm_cpu.sv ***
// cpu bus master model issuing single-word accesses
`timescale 1ns/1ps
module femrm_cpu
(
   // clock
   input  wire logic        clock,
   // request lines
   output logic             cpu_req,
   output logic             cpu_we,
   output logic [31:0]      cpu_addr,
   output logic [31:0]      cpu_wdata
);
   initial
   begin
      cpu_req   = 1'b0;
      cpu_we    = 1'b0;
      cpu_addr  = 32'hffff_ffff;
      cpu_wdata = 32'h0000_0000;
   end
   // one request cycle, then the lines are released to junk values
   task automatic access(input logic we, input logic [31:0] addr,
                         input logic [31:0] wdata);
      @(negedge clock);
      cpu_req   = 1'b1;
      cpu_we    = we;
      cpu_addr  = addr;
      cpu_wdata = wdata;
      @(negedge clock);
      cpu_req   = 1'b0;
      cpu_we    = ~we;
      cpu_addr  = ~addr;
      cpu_wdata = ~wdata;
   endtask
endmodule

// *** test/femrm_bench.sv ***
// self-checking bench for the flash emulation ram remap block
`timescale 1ns/1ps
module femrm_bench;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        emulation_mode_bit = 1'b0;
   logic [3:0]  large_bank_enables = 4'h0;
   logic [1:0]  small_bank_enables = 2'h0;
   logic [27:0] large_bank_addr_field = 28'h0;
   logic [15:0] small_bank_addr_field = 16'h0;
   logic        cpu_req, cpu_we, flash_req, remap_hit;
   logic [31:0] cpu_addr, cpu_wdata, cpu_rdata;
   logic [2:0]  remap_source;
   logic [15:0] ram_addr;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;

   always #50 clock = ~clock;

   femrm_top femrm_top_inst (.clock(clock), .rst(rst),
      .emulation_mode_bit(emulation_mode_bit),
      .large_bank_enables(large_bank_enables),
      .small_bank_enables(small_bank_enables),
      .large_bank_addr_field(large_bank_addr_field),
      .small_bank_addr_field(small_bank_addr_field),
      .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .flash_req(flash_req), .remap_hit(remap_hit),
      .remap_source(remap_source), .ram_addr(ram_addr));
   femrm_cpu femrm_cpu_inst (.clock(clock), .cpu_req(cpu_req),
      .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         conclude();
      end
   end

   // read that must go to flash unremapped
   task automatic to_flash(input logic [31:0] addr);
      femrm_cpu_inst.access(1'b0, addr, 32'h0);
      check({31'h0, flash_req}, 32'h1);
      check({31'h0, remap_hit}, 32'h0);
   endtask

   // protect id words written as all ones pass to flash untouched
   task automatic test_protect_id;
      for (int a = 32'h84; a <= 32'h90; a += 4)
      begin
         femrm_cpu_inst.access(1'b1, 32'(a), 32'hffff_ffff);
         check({31'h0, flash_req}, 32'h1);
         check({31'h0, remap_hit}, 32'h0);
      end
   endtask

   // write then read through a window, checking the ram address
   task automatic via_ram(input logic [31:0] addr, input logic [15:0] ra,
                          input logic hit, input logic [2:0] src);
      femrm_cpu_inst.access(1'b1, addr, addr ^ 32'h5a5a_c3c3);
      check({31'h0, remap_hit}, {31'h0, hit});
      check({16'h0, ram_addr}, {16'h0, ra});
      if (hit)
         check({29'h0, remap_source}, {29'h0, src});
      femrm_cpu_inst.access(1'b0, addr, 32'h0);
      check({31'h0, flash_req}, 32'h0);
      check(cpu_rdata, addr ^ 32'h5a5a_c3c3);
   endtask

   task automatic test_mode_off;
      large_bank_addr_field[6:0] = 7'h02;
      large_bank_enables = 4'h1;
      to_flash(32'h0000_2010);
      emulation_mode_bit = 1'b1;
      large_bank_enables = 4'h0;
      to_flash(32'h0000_2010);
   endtask

   task automatic test_large;
      for (int i = 0; i < 4; i++)
         large_bank_addr_field[i*7+:7] = 7'(2 * (i + 1));
      large_bank_enables = 4'hf;
      for (int i = 0; i < 4; i++)
         via_ram(32'((i + 1) * 32'h2000 + 32'h100 + 4 * i),
                 16'(i * 32'h2000 + 32'h100 + 4 * i), 1'b1,
                 3'(i));
      large_bank_enables = 4'h0;
   endtask

   task automatic test_small;
      small_bank_addr_field = {8'h7f, 8'h01};
      small_bank_enables = 2'h3;
      via_ram(32'h0000_1ff8, 16'h8ff8, 1'b1, 3'h4);
      via_ram(32'h0007_f024, 16'h9024, 1'b1, 3'h5);
      to_flash(32'h0000_2000);
   endtask

   task automatic test_priority;
      large_bank_addr_field = {4{7'h5e}};
      small_bank_addr_field = {2{8'h5e}};
      for (int k = 0; k < 6; k++)
      begin
         {small_bank_enables, large_bank_enables} = 6'h3f << k;
         via_ram(32'h0005_e008, (k < 4) ? 16'(k * 32'h2000 + 8)
                 : 16'(32'h8000 + (k - 4) * 32'h1000 + 8), 1'b1,
                 3'(k));
      end
   endtask

   task automatic test_ram_window;
      {small_bank_enables, large_bank_enables} = 6'h3f;
      via_ram(32'h0080_403c, 16'h003c, 1'b0, 3'h0);
      via_ram(32'h0080_dffc, 16'h9ffc, 1'b0, 3'h0);
      emulation_mode_bit = 1'b0;
      to_flash(32'h0005_e008);
   endtask

   initial
   begin
      repeat (2) @(negedge clock);
      rst = 1'b0;
      test_protect_id();
      test_mode_off();
      test_large();
      test_small();
      test_priority();
      test_ram_window();
      conclude();
   end
endmodule
